// ---- bench/sfr_host.sv ----
// Host serial port model that sends frames
`timescale 1ns/1ps
module sfr_host (
  output reg sync_n,
  output reg sclk,
  output reg din
);
  integer b;
  initial
  begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // select low, MSB first, 48 ns serial period
  task frame(input [15:0] w, input integer n);
    begin
      sync_n = 1'b0;
      for (b = 0; b < n; b = b + 1)
      begin
        din = w[15 - b % 16];
        #24 sclk = 1'b0;
        #24 sclk = 1'b1;
      end
      // Released line shows the inverse, never a stale bit
      #24 sync_n = 1'b1;
      din = ~din;
      #60;
    end
  endtask
endmodule // sfr_host

// ---- bench/sfr_props.sv ----
// Port checker for the serial frame receiver
`timescale 1ns/1ps
`include "sfr_defines.vh"
module sfr_props (
  input wire                   mclk,
  input wire                   rst_n,
  input wire                   sync_n,
  input wire                   sclk,
  input wire                   din,
  input wire                   word_ready,
  input wire [`SFR_WORD_W-1:0] word_data_q,
  input wire                   word_valid_q,
  input wire                   din_buf_en_q,
  input wire                   sclk_buf_en_q,
  input wire                   frame_abort_q,
  input wire                   word_drop_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_buf_pair: assert property (din_buf_en_q == sclk_buf_en_q)
    else $error("buffer enables differ");
  chk_din_idle: assert property (sync_n [*8] |-> !din_buf_en_q)
    else $error("data buffer powered while idle");
  chk_sclk_idle: assert property (sync_n [*8] |-> !sclk_buf_en_q)
    else $error("clock buffer powered while idle");
  chk_valid_hold: assert property (word_valid_q && !word_ready |=> word_valid_q)
    else $error("word withdrawn before taken");
  chk_data_hold: assert property (word_valid_q && !word_ready |=> $stable(word_data_q))
    else $error("word changed before taken");
  chk_abort_once: assert property (frame_abort_q |=> !frame_abort_q)
    else $error("abort pulse too long");
  chk_abort_off: assert property (frame_abort_q |-> ##[0:2] !din_buf_en_q)
    else $error("buffers kept on after abort");
  chk_drop_full: assert property (word_drop_q |-> word_valid_q ##1 !word_drop_q)
    else $error("drop without full buffer");
  cov_take: cover property (word_valid_q && word_ready);
  cov_abort: cover property (frame_abort_q);
  cov_drop: cover property (word_drop_q);
endmodule // sfr_props
bind sfr_top sfr_props chk (.mclk(mclk), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk),
  .din(din), .word_ready(word_ready), .word_data_q(word_data_q), .word_valid_q(word_valid_q),
  .din_buf_en_q(din_buf_en_q), .sclk_buf_en_q(sclk_buf_en_q),
  .frame_abort_q(frame_abort_q), .word_drop_q(word_drop_q));

// ---- bench/sfr_top_tb.sv ----
// Testbench for the serial frame receiver
`timescale 1ns/1ps
`include "sfr_defines.vh"
module sfr_top_tb;
  reg                    mclk = 0, rst_n = 0, word_ready = 0, hold = 0;
  wire                   sync_n, sclk, din, word_valid_q, din_buf_en_q, sclk_buf_en_q;
  wire                   frame_abort_q, word_drop_q;
  wire [`SFR_WORD_W-1:0] word_data_q;
  reg  [15:0]            exp_q[$];
  reg  [15:0]            w;
  integer                miscompares = 0, samples_checked = 0, aborts = 0, drops = 0, i;
  sfr_top dut (.mclk(mclk), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk), .din(din),
    .word_ready(word_ready), .word_data_q(word_data_q), .word_valid_q(word_valid_q),
    .din_buf_en_q(din_buf_en_q), .sclk_buf_en_q(sclk_buf_en_q),
    .frame_abort_q(frame_abort_q), .word_drop_q(word_drop_q));
  sfr_host host (.sync_n(sync_n), .sclk(sclk), .din(din));
  initial forever #2.5 mclk = ~mclk;
  task check(input [8*6-1:0] nm, input [15:0] seen, input [15:0] expv);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== expv)
      begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Random consumer stall, held off to force overflow
  always @(negedge mclk) word_ready <= hold ? 1'b0 : $urandom_range(1, 0);
  // Monitor takes the oldest note for each word handed over
  always @(posedge mclk)
  begin
    if (frame_abort_q === 1'b1) aborts = aborts + 1;
    if (word_drop_q === 1'b1) drops = drops + 1;
    if (word_valid_q === 1'b1 && word_ready === 1'b1)
      check("word", word_data_q, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end
  initial
  begin
    void'($urandom(34));
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    check("bufen", din_buf_en_q, 16'h0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      w = $urandom;
      exp_q.push_back(w);
      // Mid-frame probe: buffers must be powered while bits shift in
      fork
        host.frame(w, 16);
        begin
          #400;
          check("bufon", {din_buf_en_q, sclk_buf_en_q}, 16'h0003);
        end
      join
      check("bufoff", {din_buf_en_q, sclk_buf_en_q}, 16'h0000);
    end
    // Aborts at first, middle and last edge before the word ends
    for (i = 1; i < 16; i = i + 7) host.frame($urandom, i);
    check("bufoff", {din_buf_en_q, sclk_buf_en_q}, 16'h0000);
    w = $urandom;
    exp_q.push_back(w);
    host.frame(w, 20);
    hold = 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      w = $urandom;
      if (i < 2) exp_q.push_back(w);
      host.frame(w, 16);
    end
    hold = 1'b0;
    for (i = 0; i < 2000 && exp_q.size() > 0; i = i + 1) @(posedge mclk);
    if (exp_q.size() > 0) miscompares = miscompares + 1;
    check("aborts", aborts, 16'h0003);
    check("drops", drops, 16'h0001);
    results;
  end
  initial
  begin
    #400000 miscompares = miscompares + 1;
    results;
  end
endmodule // sfr_top_tb

// ---- verilog/sfr_defines.vh ----
// Constants for the serial frame receiver
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
`define SFR_WORD_W      16
`define SFR_CNT_W       5
`define SFR_WORD_BITS   5'h10
`define SFR_SYNC_STAGES 3
`define SFR_CLK_MHZ     200
`define SFR_SCLK_MAX_MHZ 30
// Least system cycles per serial half period at the top serial rate
`define SFR_MIN_HALF_CYC ((`SFR_CLK_MHZ + 2 * `SFR_SCLK_MAX_MHZ - 1) / (2 * `SFR_SCLK_MAX_MHZ))
`define SFR_WORD_RST    16'h0000
`endif

// ---- verilog/sfr_top.v ----
// Serial frame receiver: 16-bit shift-in port with a two-entry word buffer
//
// Function
// - Sixteen-bit input shift register collects words
// - Data shifted in on falling serial clock
// - Data input buffer off after write
// - Clock input buffer off after write
// - Low frame select enables next sixteen edges
// - Early frame select rise discards partial word
`timescale 1ns/1ps
`include "sfr_defines.vh"

module sfr_top (
  input  wire                   mclk,
  input  wire                   rst_n,
  input  wire                   sync_n,
  input  wire                   sclk,
  input  wire                   din,
  input  wire                   word_ready,
  output reg  [`SFR_WORD_W-1:0] word_data_q,
  output reg                    word_valid_q,
  output reg                    din_buf_en_q,
  output reg                    sclk_buf_en_q,
  output reg                    frame_abort_q,
  output reg                    word_drop_q
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire      rst_loc_n;

  // Asynchronous assert, synchronous release
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_loc_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] sync_sh_q;
  reg [2:0] sclk_sh_q;
  reg [2:0] din_sh_q;
  reg       sync_n_q;
  reg       sclk_q;

  // Three stages; stage 0 read only by stage 1
  always @(posedge mclk or negedge rst_loc_n)
  begin
    if (!rst_loc_n)
    begin
      sync_sh_q <= 3'b111;
      sclk_sh_q <= 3'b111;
      din_sh_q  <= 3'b000;
    end
    else
    begin
      sync_sh_q <= {sync_sh_q[1:0], sync_n};
      sclk_sh_q <= {sclk_sh_q[1:0], sclk};
      din_sh_q  <= {din_sh_q[1:0], din};
    end
  end

  // A level counts once stages 1 and 2 agree
  always @(posedge mclk or negedge rst_loc_n)
  begin
    if (!rst_loc_n)
    begin
      sync_n_q <= 1'b1;
      sclk_q   <= 1'b1;
    end
    else
    begin
      if (sync_sh_q[1] == sync_sh_q[2])
        sync_n_q <= sync_sh_q[2];
      if (sclk_sh_q[1] == sclk_sh_q[2])
        sclk_q <= sclk_sh_q[2];
    end
  end

  // Data sampled from the same delay depth as the clock
  wire sclk_fall = sclk_q & ~sclk_sh_q[2] & ~sclk_sh_q[1];
  wire sync_rise = ~sync_n_q & sync_sh_q[2] & sync_sh_q[1];
  wire sync_low  = ~sync_n_q;

  // ------------------------------------------------------------
  // Frame state machine
  // ------------------------------------------------------------
  localparam ST_IDLE  = 2'd0;
  localparam ST_SHIFT = 2'd1;
  localparam ST_DONE  = 2'd2;

  reg [1:0]              state_q;
  reg [1:0]              state_d;
  reg [`SFR_WORD_W-1:0]  shift_q;
  reg [`SFR_CNT_W-1:0]   cnt_q;
  reg                    push_q;
  wire                   in_ready;

  // Next state from frame select and bit count
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (sync_low)
          state_d = ST_SHIFT;
      ST_SHIFT:
        if (sync_rise)
          state_d = ST_IDLE;
        else if (sclk_fall && cnt_q == `SFR_WORD_BITS - 5'h01)
          state_d = ST_DONE;
      ST_DONE:
        if (sync_rise)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // host rate
  // Edge detect assumes each serial half period spans several mclk cycles
  always @(posedge mclk or negedge rst_loc_n)
  begin
    if (!rst_loc_n)
    begin
      state_q       <= ST_IDLE;
      shift_q       <= `SFR_WORD_RST;
      cnt_q         <= 5'h00;
      push_q        <= 1'b0;
      frame_abort_q <= 1'b0;
      din_buf_en_q  <= 1'b0;
      sclk_buf_en_q <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      push_q        <= 1'b0;
      frame_abort_q <= 1'b0;
      din_buf_en_q  <= (state_d == ST_SHIFT);
      sclk_buf_en_q <= (state_d == ST_SHIFT);
      if (state_q == ST_IDLE)
        cnt_q <= 5'h00;
      if (state_q == ST_SHIFT && sync_rise)
      begin
        cnt_q         <= 5'h00;
        frame_abort_q <= 1'b1;
      end
      else if (state_q == ST_SHIFT && sclk_fall)
      begin
        shift_q <= {shift_q[`SFR_WORD_W-2:0], din_sh_q[2]};
        cnt_q   <= cnt_q + 5'h01;
        if (cnt_q == `SFR_WORD_BITS - 5'h01)
          push_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Two-entry output buffer
  // ------------------------------------------------------------
  reg [`SFR_WORD_W-1:0] mem_q [0:1];
  reg                   wr_ptr_q;
  reg                   rd_ptr_q;
  reg [1:0]             fill_q;
  wire                  do_push = push_q & in_ready;
  wire                  do_pop  = word_valid_q & word_ready;

  // Serial side cannot stall; a word arriving when full, with no word taken that cycle, is counted as dropped
  assign in_ready = (fill_q != 2'd2) | do_pop;

  always @(posedge mclk)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= shift_q;
  end

  // Pointers, fill level and registered output
  always @(posedge mclk or negedge rst_loc_n)
  begin
    if (!rst_loc_n)
    begin
      wr_ptr_q     <= 1'b0;
      rd_ptr_q     <= 1'b0;
      fill_q       <= 2'd0;
      word_valid_q <= 1'b0;
      word_data_q  <= `SFR_WORD_RST;
      word_drop_q  <= 1'b0;
    end
    else
    begin
      word_drop_q <= push_q & ~in_ready;
      if (do_push)
        wr_ptr_q <= ~wr_ptr_q;
      if (do_pop)
        rd_ptr_q <= ~rd_ptr_q;
      fill_q <= fill_q + {1'b0, do_push} - {1'b0, do_pop};
      // Head word loads when output empties or is taken
      if (!word_valid_q || do_pop)
      begin
        if (fill_q > {1'b0, do_pop})
        begin
          word_valid_q <= 1'b1;
          word_data_q  <= mem_q[rd_ptr_q ^ do_pop];
        end
        else if (do_push)
        begin
          word_valid_q <= 1'b1;
          word_data_q  <= shift_q;
        end
        else
          word_valid_q <= 1'b0;
      end
    end
  end

endmodule // sfr_top
